//--- common/slcr_pkg.sv
// Package of offsets, fields, reset values and codes for the serial link config registers
//
// Contract
// - Top bit of the scrambling control register set means lane data is scrambled, clear means not.
// - Frame-size code 01 selects 20X with two octets per frame, code 11 selects 40X with four.
// - The low five bits of the multiframe register give the frames per multiframe.
// - After reset the multiframe length in use is 8 frames in 20X mode.
// - Subclass code 000 is subclass 0, 001 is subclass 1 (timing pulse), 010 is subclass 2 (pin).
// - Writing one to the software resync bit raises a sync request only while the source select is set.
// - Source select clear takes sync requests from the pins, set takes them from the software bit.
// - A four-bit drive field picks the lane buffer current, reset code 0000 being nominal.
// - The programmed octets per frame apply only with the frame-size override set, else 20X F=2.
// - The programmed multiframe length applies only with the multiframe override set, else default.
`default_nettype none
package slcr_pkg;
    // ------------------------------------------------------------------
    // Register offsets (byte addresses, one byte each except the ten-bit status)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_SCRAMBLE  = 8'h2F;
    localparam logic [7:0] OFS_FRAME     = 8'h30;
    localparam logic [7:0] OFS_MULTI     = 8'h31;
    localparam logic [7:0] OFS_SUBCLASS  = 8'h34;
    localparam logic [7:0] OFS_RESYNC    = 8'h3A;
    localparam logic [7:0] OFS_TEST      = 8'h3B;
    localparam logic [7:0] OFS_OVERRIDE  = 8'h2B;
    localparam logic [7:0] OFS_STATUS    = 8'h40;

    // ------------------------------------------------------------------
    // Field positions and masks of writable bits
    // ------------------------------------------------------------------
    localparam int         SCR_EN_BIT    = 7;
    localparam int         RS_REQ_BIT    = 7;
    localparam int         RS_SEL_BIT    = 6;
    localparam int         OVR_K_BIT     = 1;
    localparam int         OVR_F_BIT     = 0;
    localparam logic [7:0] MASK_SCRAMBLE = 8'h80;
    localparam logic [7:0] MASK_FRAME    = 8'hFF;
    localparam logic [7:0] MASK_MULTI    = 8'h1F;
    localparam logic [7:0] MASK_SUBCLASS = 8'hE0;
    localparam logic [7:0] MASK_RESYNC   = 8'hCF;
    localparam logic [7:0] MASK_TEST     = 8'hF7;
    localparam logic [7:0] MASK_OVERRIDE = 8'h03;
    localparam logic [7:0] REG_RESET     = 8'h00;

    // ------------------------------------------------------------------
    // Codes and defaults
    // ------------------------------------------------------------------
    localparam logic [7:0] F_CODE_20X    = 8'h01;
    localparam logic [7:0] F_CODE_40X    = 8'h03;
    localparam logic [2:0] OCTETS_20X    = 3'h2;
    localparam logic [2:0] OCTETS_40X    = 3'h4;
    localparam logic [4:0] K_DEFAULT_20X = 5'h08;
    localparam logic [3:0] DRIVE_NOMINAL = 4'h0;

    typedef enum logic [1:0] {
        SLCR_SUB0 = 2'b00,
        SLCR_SUB1 = 2'b01,
        SLCR_SUB2 = 2'b10,
        SLCR_SUBX = 2'b11
    } slcr_sub_t;
endpackage
`default_nettype wire

//--- core/slcr_sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module slcr_sync2 (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_r;
    logic meta_nxt;
    logic q_nxt;

    // First stage is read only by the second
    always_comb begin
        meta_nxt = d_i;
        q_nxt    = meta_r;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            q_o    <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            q_o    <= q_nxt;
        end
    end
endmodule // slcr_sync2
`default_nettype wire

//--- core/slcr_regs.sv
// Wishbone register bank steering scrambling, framing, subclass, resync and drive
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module slcr_regs (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic        resync_pin_pos_i,
    input  wire logic        resync_pin_neg_i,
    output logic             scramble_en_o,
    output logic      [2:0]  octets_per_frame_o,
    output logic             mode_40x_o,
    output logic      [4:0]  frames_per_multi_o,
    output logic      [1:0]  link_subclass_select_o,
    output logic             sync_request_o,
    output logic      [3:0]  drive_current_o,
    output logic      [2:0]  link_pattern_select_o,
    output logic             random_pattern_disparity_flip_o,
    output logic      [2:0]  timing_pulse_filter_o
);
    logic [7:0] scr_r, frm_r, mul_r, sub_r, rsy_r, tst_r, ovr_r;
    logic [7:0] scr_nxt, frm_nxt, mul_nxt, sub_nxt, rsy_nxt, tst_nxt, ovr_nxt;
    logic [31:0] dat_nxt;
    logic        ack_nxt;
    logic        err_nxt;
    logic        pin_p_s;
    logic        pin_n_s;
    logic        scr_nxt_o;
    logic [2:0]  opf_nxt;
    logic        m40_nxt;
    logic [4:0]  fpm_nxt;
    logic [1:0]  sub_sel_nxt;
    logic        sreq_nxt;

    // Masked byte-lane write of one register
    function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [7:0] din,
                                           input logic [7:0] mask);
        wr_byte = (old & ~mask) | (din & mask);
    endfunction

    // Decode of the three-bit subclass field
    function automatic logic [1:0] dec_sub(input logic [2:0] code);
        unique case (code)
            3'b000: dec_sub = slcr_pkg::SLCR_SUB0;
            3'b001: dec_sub = slcr_pkg::SLCR_SUB1;
            3'b010: dec_sub = slcr_pkg::SLCR_SUB2;
            default: dec_sub = slcr_pkg::SLCR_SUBX;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers for the differential request pair
    // ------------------------------------------------------------------
    slcr_sync2 u_sync_p (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (resync_pin_pos_i),
        .q_o   (pin_p_s)
    );
    slcr_sync2 u_sync_n (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (resync_pin_neg_i),
        .q_o   (pin_n_s)
    );

    // Bus slave: ack one cycle after strobe, dropped the next cycle
    always_comb begin
        logic hit;
        logic wr;
        hit     = 1'b1;
        wr      = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o && wb_sel_i[0];
        scr_nxt = scr_r;
        frm_nxt = frm_r;
        mul_nxt = mul_r;
        sub_nxt = sub_r;
        rsy_nxt = rsy_r;
        tst_nxt = tst_r;
        ovr_nxt = ovr_r;
        dat_nxt = 32'h0000_0000;
        unique case (wb_adr_i)
            slcr_pkg::OFS_SCRAMBLE: begin
                dat_nxt[7:0] = scr_r;
                if (wr) scr_nxt = wr_byte(scr_r, wb_dat_i[7:0], slcr_pkg::MASK_SCRAMBLE);
            end
            slcr_pkg::OFS_FRAME: begin
                dat_nxt[7:0] = frm_r;
                if (wr) frm_nxt = wr_byte(frm_r, wb_dat_i[7:0], slcr_pkg::MASK_FRAME);
            end
            slcr_pkg::OFS_MULTI: begin
                dat_nxt[7:0] = mul_r;
                if (wr) mul_nxt = wr_byte(mul_r, wb_dat_i[7:0], slcr_pkg::MASK_MULTI);
            end
            slcr_pkg::OFS_SUBCLASS: begin
                dat_nxt[7:0] = sub_r;
                if (wr) sub_nxt = wr_byte(sub_r, wb_dat_i[7:0], slcr_pkg::MASK_SUBCLASS);
            end
            slcr_pkg::OFS_RESYNC: begin
                dat_nxt[7:0] = rsy_r;
                if (wr) rsy_nxt = wr_byte(rsy_r, wb_dat_i[7:0], slcr_pkg::MASK_RESYNC);
            end
            slcr_pkg::OFS_TEST: begin
                dat_nxt[7:0] = tst_r;
                if (wr) tst_nxt = wr_byte(tst_r, wb_dat_i[7:0], slcr_pkg::MASK_TEST);
            end
            slcr_pkg::OFS_OVERRIDE: begin
                dat_nxt[7:0] = ovr_r;
                if (wr) ovr_nxt = wr_byte(ovr_r, wb_dat_i[7:0], slcr_pkg::MASK_OVERRIDE);
            end
            slcr_pkg::OFS_STATUS: begin
                // Effective link state as the transmitter uses it
                dat_nxt[4:0] = frames_per_multi_o;
                dat_nxt[7:5] = octets_per_frame_o;
                dat_nxt[8]   = sync_request_o;
                dat_nxt[9]   = scramble_en_o;
            end
            default: hit = 1'b0;
        endcase
        ack_nxt = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && hit;
        err_nxt = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !hit;
        if (!ack_nxt) dat_nxt = 32'h0000_0000;
    end

    // Effective link settings, all registered so outputs come from flops
    always_comb begin
        scr_nxt_o = scr_r[slcr_pkg::SCR_EN_BIT];
        opf_nxt   = slcr_pkg::OCTETS_20X;
        m40_nxt   = 1'b0;
        if (ovr_r[slcr_pkg::OVR_F_BIT] && frm_r == slcr_pkg::F_CODE_40X) begin
            opf_nxt = slcr_pkg::OCTETS_40X;
            m40_nxt = 1'b1;
        end
        // Override with F_CODE_20X or any other code keeps 20X
        fpm_nxt   = slcr_pkg::K_DEFAULT_20X;
        if (ovr_r[slcr_pkg::OVR_K_BIT]) begin
            fpm_nxt = mul_r[4:0];
        end
        sub_sel_nxt = dec_sub(sub_r[7:5]);
        // Pins are active low: request while pos is below neg
        sreq_nxt  = rsy_r[slcr_pkg::RS_SEL_BIT] ? rsy_r[slcr_pkg::RS_REQ_BIT]
                                                : (!pin_p_s && pin_n_s);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scr_r    <= slcr_pkg::REG_RESET;
            frm_r    <= slcr_pkg::REG_RESET;
            mul_r    <= slcr_pkg::REG_RESET;
            sub_r    <= slcr_pkg::REG_RESET;
            rsy_r    <= slcr_pkg::REG_RESET;
            tst_r    <= slcr_pkg::REG_RESET;
            ovr_r    <= slcr_pkg::REG_RESET;
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            scramble_en_o          <= 1'b0;
            octets_per_frame_o     <= slcr_pkg::OCTETS_20X;
            mode_40x_o             <= 1'b0;
            frames_per_multi_o     <= slcr_pkg::K_DEFAULT_20X;
            link_subclass_select_o <= slcr_pkg::SLCR_SUB0;
            sync_request_o         <= 1'b0;
            drive_current_o        <= slcr_pkg::DRIVE_NOMINAL;
            link_pattern_select_o  <= 3'h0;
            random_pattern_disparity_flip_o <= 1'b0;
            timing_pulse_filter_o  <= 3'h0;
        end else begin
            scr_r    <= scr_nxt;
            frm_r    <= frm_nxt;
            mul_r    <= mul_nxt;
            sub_r    <= sub_nxt;
            rsy_r    <= rsy_nxt;
            tst_r    <= tst_nxt;
            ovr_r    <= ovr_nxt;
            wb_dat_o <= dat_nxt;
            wb_ack_o <= ack_nxt;
            wb_err_o <= err_nxt;
            scramble_en_o          <= scr_nxt_o;
            octets_per_frame_o     <= opf_nxt;
            mode_40x_o             <= m40_nxt;
            frames_per_multi_o     <= fpm_nxt;
            link_subclass_select_o <= sub_sel_nxt;
            sync_request_o         <= sreq_nxt;
            drive_current_o        <= rsy_r[3:0];
            link_pattern_select_o  <= tst_r[7:5];
            random_pattern_disparity_flip_o <= tst_r[4];
            timing_pulse_filter_o  <= tst_r[2:0];
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_SCRAMBLE: assert property (@(posedge clk_i) disable iff (rst_i)
        scramble_en_o == $past(scr_r[slcr_pkg::SCR_EN_BIT]))
        else $error("scramble enable does not follow its bit");
    AST_FRAME_40X: assert property (@(posedge clk_i) disable iff (rst_i)
        (ovr_r[0] && frm_r == slcr_pkg::F_CODE_40X) |=> (octets_per_frame_o == 3'h4 && mode_40x_o))
        else $error("40X code not applied");
    AST_FRAME_DEF: assert property (@(posedge clk_i) disable iff (rst_i)
        !ovr_r[0] |=> (octets_per_frame_o == 3'h2 && !mode_40x_o))
        else $error("frame size changed without override");
    AST_MULTI_PROG: assert property (@(posedge clk_i) disable iff (rst_i)
        ovr_r[1] |=> frames_per_multi_o == $past(mul_r[4:0]))
        else $error("programmed multiframe length not used");
    AST_MULTI_DEF: assert property (@(posedge clk_i) disable iff (rst_i)
        !ovr_r[1] |=> frames_per_multi_o == 5'h08)
        else $error("default multiframe length not used");
    AST_RESET_K: assert property (@(posedge clk_i)
        $fell(rst_i) |-> frames_per_multi_o == 5'h08 && octets_per_frame_o == 3'h2)
        else $error("reset multiframe length wrong");
    AST_SUBCLASS: assert property (@(posedge clk_i) disable iff (rst_i)
        (sub_r[7:5] == 3'b001) |=> link_subclass_select_o == 2'b01)
        else $error("subclass 1 not selected");
    AST_SUBCLASS2: assert property (@(posedge clk_i) disable iff (rst_i)
        (sub_r[7:5] == 3'b010) |=> link_subclass_select_o == 2'b10)
        else $error("subclass 2 not selected");
    AST_SW_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
        (rsy_r[7:6] == 2'b11) |=> sync_request_o)
        else $error("software sync request lost");
    AST_PIN_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
        (!rsy_r[6] && !resync_pin_pos_i && resync_pin_neg_i) [*3] |=> sync_request_o)
        else $error("pin sync request not taken");
    AST_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i)
        drive_current_o == $past(rsy_r[3:0]))
        else $error("drive code does not follow register");
    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule // slcr_regs
`default_nettype wire

//--- test/slcr_rx_model.sv
// Receiver-side model that drives the differential resync pins
`timescale 1ns/100ps
`default_nettype none
module slcr_rx_model (
    input  wire logic clk_i,
    input  wire logic req_i,
    output var  logic pin_pos_o,
    output var  logic pin_neg_o
);
    // ------------------------------------------------------------------
    // Pin driver
    // ------------------------------------------------------------------
    // Idle pair is pos high, neg low, so no request shows before the first edge
    initial begin
        pin_pos_o = 1'h1;
        pin_neg_o = 1'h0;
    end

    // Request is pos low and neg high; pins move only just after an edge
    always @(posedge clk_i) begin
        pin_pos_o <= ~req_i;
        pin_neg_o <= req_i;
    end
endmodule // slcr_rx_model
`default_nettype wire

//--- test/serial_link_config_regs_tb.sv
// Self-checking bench for the serial link config register bank
`timescale 1ns/100ps
`default_nettype none
module serial_link_config_regs_tb;
    logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0]  wb_sel_i, drive_current_o;
    logic        pin_pos, pin_neg, rx_req, rsp_err, scramble_en_o, mode_40x_o;
    logic        sync_request_o, random_pattern_disparity_flip_o;
    logic [2:0]  octets_per_frame_o, link_pattern_select_o, timing_pulse_filter_o;
    logic [4:0]  frames_per_multi_o;
    logic [1:0]  link_subclass_select_o;
    int          err_count, num_checks;
    // Offsets and legal values with reserved bits zero and K not below 8
    logic [7:0]  rofs [7] = '{8'h2B, 8'h2F, 8'h30, 8'h31, 8'h34, 8'h3A, 8'h3B};
    logic [7:0]  rval [7] = '{8'h00, 8'h80, 8'h03, 8'h10, 8'h40, 8'h05, 8'h95};

    slcr_regs uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .resync_pin_pos_i(pin_pos), .resync_pin_neg_i(pin_neg),
        .scramble_en_o(scramble_en_o), .octets_per_frame_o(octets_per_frame_o),
        .mode_40x_o(mode_40x_o), .frames_per_multi_o(frames_per_multi_o),
        .link_subclass_select_o(link_subclass_select_o), .sync_request_o(sync_request_o),
        .drive_current_o(drive_current_o), .link_pattern_select_o(link_pattern_select_o),
        .random_pattern_disparity_flip_o(random_pattern_disparity_flip_o),
        .timing_pulse_filter_o(timing_pulse_filter_o));

    slcr_rx_model rx (.clk_i(clk_i), .req_i(rx_req), .pin_pos_o(pin_pos), .pin_neg_o(pin_neg));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_dat(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected read data at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected output at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Classic cycle: held until ack or err is seen high at a rising edge
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h00_0000, dat};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1 && n < 20);
        if (n >= 20) begin
            err_count++;
            complete_run();
        end
        rd = wb_dat_o;
        rsp_err = wb_err_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i  <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        wb_cycle(1'h1, adr, dat);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        wb_cycle(1'h0, adr, 8'h00);
        chk_dat(rd, exp);
    endtask

    // Derived outputs follow the register one cycle later
    task automatic settle();
        repeat (2) @(posedge clk_i);
    endtask

    // ------------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------------
    initial begin
        clk_i = 1'h0;
        forever #20 clk_i = ~clk_i;
    end

    initial begin
        rst_i = 1'h1;
        {wb_we_i, wb_cyc_i, wb_stb_i, rx_req} = 4'h0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0000_0000;
        wb_sel_i = 4'hF;
        err_count = 0;
        num_checks = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        for (int i = 0; i < 7; i++) rd_chk(rofs[i], 32'h0000_0000);
        rd_chk(slcr_pkg::OFS_STATUS, 32'h0000_0048);
        chk_out(frames_per_multi_o, 32'h0000_0008);
        for (int i = 0; i < 7; i++) begin
            wr(rofs[i], rval[i]);
            rd_chk(rofs[i], {24'h00_0000, rval[i]});
        end
        settle();
        chk_out(scramble_en_o, 32'h0000_0001);
        chk_out(octets_per_frame_o, 32'h0000_0002);
        chk_out(mode_40x_o, 32'h0000_0000);
        chk_out(frames_per_multi_o, 32'h0000_0008);
        chk_out(drive_current_o, 32'h0000_0005);
        chk_out({link_pattern_select_o, random_pattern_disparity_flip_o,
                 timing_pulse_filter_o}, 32'h0000_004D);
        wr(slcr_pkg::OFS_OVERRIDE, 8'h03);
        settle();
        chk_out(octets_per_frame_o, 32'h0000_0004);
        chk_out(mode_40x_o, 32'h0000_0001);
        chk_out(frames_per_multi_o, 32'h0000_0010);
        rd_chk(slcr_pkg::OFS_STATUS, 32'h0000_0290);
        wr(slcr_pkg::OFS_FRAME, 8'h01);
        settle();
        chk_out({mode_40x_o, octets_per_frame_o}, 32'h0000_0002);
        // Code 011 is undefined and must decode to the illegal marker 3
        for (int c = 0; c < 4; c++) begin
            wr(slcr_pkg::OFS_SUBCLASS, 8'(c << 5));
            settle();
            chk_out(link_subclass_select_o, c);
        end
        wr(slcr_pkg::OFS_SCRAMBLE, 8'h00);
        settle();
        chk_out(scramble_en_o, 32'h0000_0000);
        // Pin request with source select clear, then released
        rx_req <= 1'h1;
        repeat (5) @(posedge clk_i);
        chk_out(sync_request_o, 32'h0000_0001);
        rx_req <= 1'h0;
        repeat (5) @(posedge clk_i);
        chk_out(sync_request_o, 32'h0000_0000);
        wr(slcr_pkg::OFS_RESYNC, 8'h80);
        settle();
        chk_out(sync_request_o, 32'h0000_0000);
        wr(slcr_pkg::OFS_RESYNC, 8'h40);
        rx_req <= 1'h1;
        repeat (5) @(posedge clk_i);
        chk_out(sync_request_o, 32'h0000_0000);
        wr(slcr_pkg::OFS_RESYNC, 8'hC0);
        settle();
        chk_out(sync_request_o, 32'h0000_0001);
        rx_req <= 1'h0;
        wr(slcr_pkg::OFS_RESYNC, 8'h00);
        // Unmapped address is refused, read-only status ignores writes
        wr(8'h2C, 8'h01);
        chk_out(rsp_err, 32'h0000_0001);
        wb_cycle(1'h0, 8'h2C, 8'h00);
        chk_out(rsp_err, 32'h0000_0001);
        wr(slcr_pkg::OFS_STATUS, 8'hFF);
        rd_chk(slcr_pkg::OFS_STATUS, 32'h0000_0050);
        // Second reset in mid-run clears the override
        @(posedge clk_i);
        rst_i <= 1'h1;
        @(posedge clk_i);
        rst_i <= 1'h0;
        rd_chk(slcr_pkg::OFS_OVERRIDE, 32'h0000_0000);
        settle();
        chk_out(frames_per_multi_o, 32'h0000_0008);
        complete_run();
    end
endmodule // serial_link_config_regs_tb
`default_nettype wire
